// file: rtl/cbcu_regs.svh
// Address map and reset values of the internal bus cycle unit
`ifndef CBCU_REGS_SVH
`define CBCU_REGS_SVH

// On-chip memory windows (two-state, 16-bit path)
`define CBCU_ROM_LO     16'h0000
`define CBCU_ROM_HI     16'hdfff
`define CBCU_RAM_LO     16'he800
`define CBCU_RAM_HI     16'hefff
// Peripheral register window and its sub-ranges
`define CBCU_IO_LO      16'hff00
`define CBCU_IO_HI      16'hffff
`define CBCU_IO16_LO    16'hff00
`define CBCU_IO16_HI    16'hff3f
`define CBCU_IO3_LO     16'hff40
`define CBCU_IO3_HI     16'hff7f
// Registers held inside this unit
`define CBCU_TMR_ADDR   16'hffd0
`define CBCU_PDATA_ADDR 16'hffd8
`define CBCU_PDIR_ADDR  16'hffe8
// Read values and reset values
`define CBCU_DIR_READ   8'hff
`define CBCU_EMPTY_RD   8'hff
`define CBCU_PORT_RST   8'h00
`define CBCU_TMR_RST    8'h00
`define CBCU_TMR_TOP    8'hff
`define CBCU_BIT_ONE    8'h01
`define CBCU_ZERO16     16'h0000

`endif

// file: rtl/cbcu_pkg.sv
// Types shared by the internal bus cycle unit
package cbcu_pkg;

    // Bus cycle states, Gray along T1 -> T2 -> T3
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_T1   = 2'b01,
        ST_T2   = 2'b11,
        ST_T3   = 2'b10
    } cbcu_state_e;

    // Kind of job the CPU hands over
    typedef enum logic [1:0] {
        JOB_ACC  = 2'b00,
        JOB_RMW  = 2'b01,
        JOB_MOVE = 2'b10
    } cbcu_job_e;

    // Bit manipulation operations
    typedef enum logic [2:0] {
        OP_SET = 3'h0,
        OP_CLR = 3'h1,
        OP_NOT = 3'h2,
        OP_ST  = 3'h3,
        OP_IST = 3'h4
    } cbcu_bitop_e;

    // Top-level processor states, Gray along reset -> exc -> exec -> halt
    typedef enum logic [1:0] {
        CPU_RESET = 2'b00,
        CPU_EXC   = 2'b01,
        CPU_EXEC  = 2'b11,
        CPU_HALT  = 2'b10
    } cbcu_cpu_e;

    // Sub-modes of execution and halt
    typedef enum logic [2:0] {
        SUB_ACTIVE    = 3'h0,
        SUB_SUBACTIVE = 3'h1,
        SUB_SLEEP     = 3'h2,
        SUB_STANDBY   = 3'h3,
        SUB_SUBSLEEP  = 3'h4
    } cbcu_sub_e;

endpackage

// file: rtl/cbcu_bus_cycle_unit.sv
// Internal bus cycle unit: memory/peripheral cycles, bit ops, block move
`timescale 1ns/1ps
`default_nettype none
`include "cbcu_regs.svh"

module cbcu_bus_cycle_unit
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire cbcu_pkg::cbcu_job_e   req_job,
    input  wire logic [15:0]           req_addr,
    input  wire logic                  req_write,
    input  wire logic                  req_word,
    input  wire logic [15:0]           req_wdata,
    input  wire cbcu_pkg::cbcu_bitop_e req_bitop,
    input  wire logic [2:0]            req_bitnum,
    input  wire logic                  req_carry,
    input  wire logic [7:0]            move_count_reg,
    input  wire logic [15:0]           move_source_reg,
    input  wire logic [15:0]           move_dest_reg,
    output logic                       rsp_valid,
    output logic [15:0]                rsp_rdata,
    output logic                       rsp_err,
    output logic                       mem_sel,
    output logic                       mem_we,
    output logic [1:0]                 mem_be,
    output logic [15:0]                mem_addr,
    output logic [15:0]                mem_wdata,
    input  wire logic [15:0]           mem_rdata,
    output logic                       per_sel,
    output logic                       per_we,
    output logic                       per_word,
    output logic [15:0]                per_addr,
    output logic [15:0]                per_wdata,
    input  wire logic [15:0]           per_rdata,
    input  wire logic [7:0]            port_pin_i,
    output logic [7:0]                 port_pin_o,
    output logic [7:0]                 port_pin_oe,
    input  wire logic                  exc_req,
    input  wire logic                  exc_done,
    input  wire logic                  halt_req,
    input  wire cbcu_pkg::cbcu_sub_e   halt_kind,
    input  wire logic                  wake_req,
    input  wire logic                  subclk_sel,
    output cbcu_pkg::cbcu_cpu_e        cpu_state,
    output cbcu_pkg::cbcu_sub_e        cpu_submode
);
    import cbcu_pkg::*;

    // ****************
    // State and job registers
    // ****************
    cbcu_state_e  st_ff,    nxt_st;
    cbcu_job_e    job_ff,   nxt_job;
    cbcu_bitop_e  op_ff,    nxt_op;
    cbcu_cpu_e    cpu_ff,   nxt_cpu;
    cbcu_sub_e    sub_ff,   nxt_sub;
    logic [15:0]  addr_ff,  nxt_addr;
    logic [15:0]  dst_ff,   nxt_dst;
    logic [15:0]  wdat_ff,  nxt_wdat;
    logic [15:0]  rdat_ff,  nxt_rdat;
    logic [7:0]   cnt_ff,   nxt_cnt;
    logic [2:0]   bit_ff,   nxt_bit;
    logic         we_ff,    nxt_we;
    logic         word_ff,  nxt_word;
    logic         ph2_ff,   nxt_ph2;
    logic         carry_ff, nxt_carry;
    logic         err_ff,   nxt_err;
    logic         done_ff,  nxt_done;
    logic [7:0]   latch_ff;
    logic [7:0]   dir_ff;
    logic [7:0]   tcnt_ff;
    logic [7:0]   trld_ff;

    // ****************
    // Address decode of the current cycle
    // ****************
    wire [15:0] cyc_addr  = ph2_ff ? {addr_ff[15:1], 1'b1} : addr_ff;
    wire        is_rom    = (cyc_addr >= `CBCU_ROM_LO)
                            && (cyc_addr <= `CBCU_ROM_HI);
    wire        is_ram    = (cyc_addr >= `CBCU_RAM_LO)
                            && (cyc_addr <= `CBCU_RAM_HI);
    wire        is_mem    = is_rom || is_ram;
    wire        is_io     = (cyc_addr >= `CBCU_IO_LO)
                            && (cyc_addr <= `CBCU_IO_HI);
    wire        is_io16   = is_io && (cyc_addr >= `CBCU_IO16_LO)
                            && (cyc_addr <= `CBCU_IO16_HI);
    wire        is_io3    = is_io && (cyc_addr >= `CBCU_IO3_LO)
                            && (cyc_addr <= `CBCU_IO3_HI);
    wire        is_pdata  = (cyc_addr == `CBCU_PDATA_ADDR);
    wire        is_pdir   = (cyc_addr == `CBCU_PDIR_ADDR);
    wire        is_tmr    = (cyc_addr == `CBCU_TMR_ADDR);
    wire        is_int    = is_pdata || is_pdir || is_tmr;
    // byte access to wide register refused
    wire        bad_width = is_io16 && !word_ff;
    wire        bad       = (!is_mem && !is_io) || bad_width;
    wire        busy      = (st_ff != ST_IDLE);
    // word to an 8-bit register splits
    wire        need_split = word_ff && is_io && !is_io16;
    wire        wide      = word_ff && (is_mem || is_io16);
    // two states, or three on slow registers
    wire        last_st   = ((st_ff == ST_T2) && !is_io3)
                            || (st_ff == ST_T3);

    // ****************
    // Data lanes, even byte on the upper lane except in peripheral byte cycles
    // ****************
    // even byte first, from the upper half
    wire [7:0]  wr_byte   = (word_ff && !ph2_ff) ? wdat_ff[15:8]
                                                 : wdat_ff[7:0];
    wire [7:0]  port_rd   = (dir_ff & latch_ff) | (~dir_ff & port_pin_i);
    wire [7:0]  mem_byte  = cyc_addr[0] ? mem_rdata[7:0]
                                        : mem_rdata[15:8];
    wire [7:0]  rd_byte   = is_mem    ? mem_byte :
                            bad       ? `CBCU_EMPTY_RD :
                            is_pdata  ? port_rd :
                            is_pdir   ? `CBCU_DIR_READ :
                            is_tmr    ? tcnt_ff : per_rdata[7:0];
    wire [15:0] rd_word   = is_mem ? mem_rdata : per_rdata;
    wire [15:0] rd_bad16  = {`CBCU_EMPTY_RD, `CBCU_EMPTY_RD};

    // change one bit of the byte read
    wire [7:0]  bmask     = `CBCU_BIT_ONE << bit_ff;
    wire [7:0]  mod_byte  =
        (op_ff == OP_SET) ? (rd_byte | bmask) :
        (op_ff == OP_CLR) ? (rd_byte & ~bmask) :
        (op_ff == OP_NOT) ? (rd_byte ^ bmask) :
        (op_ff == OP_ST)  ? (carry_ff ? (rd_byte | bmask)
                                      : (rd_byte & ~bmask)) :
                            (carry_ff ? (rd_byte & ~bmask)
                                      : (rd_byte | bmask));

    // ****************
    // Bus outputs
    // ****************
    // memory cycle, 16-bit path
    assign mem_sel   = busy && is_mem;
    assign mem_we    = we_ff;
    assign mem_addr  = cyc_addr;
    assign mem_be    = wide ? 2'b11 : (cyc_addr[0] ? 2'b01 : 2'b10);
    assign mem_wdata = wide ? wdat_ff : {wr_byte, wr_byte};
    assign per_sel   = busy && is_io && !is_int && !bad;
    assign per_we    = we_ff;
    assign per_word  = wide;
    assign per_addr  = cyc_addr;
    assign per_wdata = wide ? wdat_ff : {8'h00, wr_byte};
    assign req_ready = !busy && (cpu_ff == CPU_EXEC) && !halt_req
                       && !exc_req;
    assign rsp_valid = done_ff;
    assign rsp_rdata = rdat_ff;
    assign rsp_err   = err_ff;
    assign port_pin_o  = latch_ff;
    assign port_pin_oe = dir_ff;
    assign cpu_state   = cpu_ff;
    assign cpu_submode = sub_ff;

    wire take     = req_valid && req_ready;
    wire int_wr   = busy && last_st && we_ff && !bad;

    // ****************
    // Sequencer
    // ****************
    // state advance on each rising clock edge
    always_comb
    begin
        nxt_st    = st_ff;
        nxt_job   = job_ff;
        nxt_op    = op_ff;
        nxt_addr  = addr_ff;
        nxt_dst   = dst_ff;
        nxt_wdat  = wdat_ff;
        nxt_rdat  = rdat_ff;
        nxt_cnt   = cnt_ff;
        nxt_bit   = bit_ff;
        nxt_we    = we_ff;
        nxt_word  = word_ff;
        nxt_ph2   = ph2_ff;
        nxt_carry = carry_ff;
        nxt_err   = err_ff;
        nxt_done  = 1'b0;
        case (st_ff)
            ST_IDLE:
            begin
                if (take)
                begin
                    nxt_job   = req_job;
                    nxt_op    = req_bitop;
                    nxt_bit   = req_bitnum;
                    nxt_carry = req_carry;
                    nxt_rdat  = `CBCU_ZERO16;
                    nxt_err   = 1'b0;
                    nxt_ph2   = 1'b0;
                    nxt_wdat  = req_wdata;
                    nxt_we    = (req_job == JOB_ACC) && req_write;
                    nxt_word  = (req_job == JOB_ACC) && req_word;
                    nxt_addr  = req_addr;
                    nxt_st    = ST_T1;
                    if (req_job == JOB_ACC && req_word)
                        nxt_addr = {req_addr[15:1], 1'b0};
                    if (req_job == JOB_MOVE)
                    begin
                        nxt_addr = move_source_reg;
                        nxt_dst  = move_dest_reg;
                        nxt_cnt  = move_count_reg;
                        if (move_count_reg == 8'h00)
                        begin
                            nxt_st   = ST_IDLE;
                            nxt_done = 1'b1;
                        end
                    end
                end
            end
            ST_T1:
                nxt_st = ST_T2;
            ST_T2, ST_T3:
            begin
                if (!last_st)
                    nxt_st = ST_T3;
                else
                begin
                    nxt_st  = ST_T1;
                    nxt_err = err_ff || bad;
                    if (!we_ff)
                    begin
                        if (wide)
                            nxt_rdat = bad ? rd_bad16 : rd_word;
                        else if (need_split && !ph2_ff)
                            nxt_rdat[15:8] = rd_byte;
                        else
                            nxt_rdat[7:0] = rd_byte;
                    end
                    case (job_ff)
                        JOB_RMW:
                        begin
                            if (!we_ff)
                            begin
                                nxt_we         = 1'b1;
                                nxt_wdat[7:0]  = mod_byte;
                            end
                            else
                            begin
                                nxt_st   = ST_IDLE;
                                nxt_done = 1'b1;
                            end
                        end
                        JOB_MOVE:
                        begin
                            if (!we_ff)
                            begin
                                nxt_we        = 1'b1;
                                nxt_wdat[7:0] = rd_byte;
                                nxt_dst       = addr_ff;
                                nxt_addr      = dst_ff;
                            end
                            else
                            begin
                                nxt_we   = 1'b0;
                                nxt_cnt  = cnt_ff - 8'h01;
                                nxt_addr = dst_ff + 16'h0001;
                                nxt_dst  = addr_ff + 16'h0001;
                                if (cnt_ff == 8'h01)
                                begin
                                    nxt_st   = ST_IDLE;
                                    nxt_done = 1'b1;
                                end
                            end
                        end
                        default:
                        begin
                            // second cycle for the odd byte
                            if (need_split && !ph2_ff)
                                nxt_ph2 = 1'b1;
                            else
                            begin
                                nxt_st   = ST_IDLE;
                                nxt_done = 1'b1;
                            end
                        end
                    endcase
                end
            end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    // ****************
    // Processor top-level state and sub-mode
    // ****************
    // reset, exception, execution, halt
    always_comb
    begin
        nxt_cpu = cpu_ff;
        case (cpu_ff)
            CPU_RESET: nxt_cpu = CPU_EXC;
            CPU_EXC:   nxt_cpu = exc_done ? CPU_EXEC : CPU_EXC;
            CPU_EXEC:
            begin
                if (!busy && exc_req)
                    nxt_cpu = CPU_EXC;
                else if (!busy && halt_req)
                    nxt_cpu = CPU_HALT;
            end
            CPU_HALT:
            begin
                if (exc_req)
                    nxt_cpu = CPU_EXC;
                else if (wake_req)
                    nxt_cpu = CPU_EXEC;
            end
            default:   nxt_cpu = CPU_RESET;
        endcase
    end

    assign nxt_sub = (nxt_cpu == CPU_HALT)
                     ? ((cpu_ff == CPU_HALT) ? sub_ff : halt_kind)
                     : (subclk_sel ? SUB_SUBACTIVE : SUB_ACTIVE);

    // Sequencer registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff    <= ST_IDLE;
            job_ff   <= JOB_ACC;
            op_ff    <= OP_SET;
            addr_ff  <= `CBCU_ZERO16;
            dst_ff   <= `CBCU_ZERO16;
            wdat_ff  <= `CBCU_ZERO16;
            rdat_ff  <= `CBCU_ZERO16;
            cnt_ff   <= 8'h00;
            bit_ff   <= 3'h0;
            we_ff    <= 1'b0;
            word_ff  <= 1'b0;
            ph2_ff   <= 1'b0;
            carry_ff <= 1'b0;
            err_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end
        else
        begin
            st_ff    <= nxt_st;
            job_ff   <= nxt_job;
            op_ff    <= nxt_op;
            addr_ff  <= nxt_addr;
            dst_ff   <= nxt_dst;
            wdat_ff  <= nxt_wdat;
            rdat_ff  <= nxt_rdat;
            cnt_ff   <= nxt_cnt;
            bit_ff   <= nxt_bit;
            we_ff    <= nxt_we;
            word_ff  <= nxt_word;
            ph2_ff   <= nxt_ph2;
            carry_ff <= nxt_carry;
            err_ff   <= nxt_err;
            done_ff  <= nxt_done;
        end
    end

    // Processor state registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cpu_ff <= CPU_RESET;
            sub_ff <= SUB_ACTIVE;
        end
        else
        begin
            cpu_ff <= nxt_cpu;
            sub_ff <= nxt_sub;
        end
    end

    // ****************
    // Port and reloadable timer held in this unit
    // ****************
    // Port latch and direction writes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latch_ff <= `CBCU_PORT_RST;
            dir_ff   <= `CBCU_PORT_RST;
        end
        else
        begin
            if (int_wr && is_pdata)
                latch_ff <= wr_byte;
            if (int_wr && is_pdir)
                dir_ff <= wr_byte;
        end
    end

    // write hits reload, counter keeps running
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tcnt_ff <= `CBCU_TMR_RST;
            trld_ff <= `CBCU_TMR_RST;
        end
        else
        begin
            tcnt_ff <= (tcnt_ff == `CBCU_TMR_TOP) ? trld_ff
                                                 : tcnt_ff + 8'h01;
            if (int_wr && is_tmr)
                trld_ff <= wr_byte;
        end
    end

endmodule

`default_nettype wire

// file: bench/cbcu_bus_cycle_unit_asserts.sv
// Timing checker bound to the internal bus cycle unit
`timescale 1ns/1ps
`default_nettype none
`include "cbcu_regs.svh"
module cbcu_bus_cycle_unit_asserts
(
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic                req_valid,
    input wire logic                req_ready,
    input wire cbcu_pkg::cbcu_job_e req_job,
    input wire logic [15:0]         req_addr,
    input wire logic                req_write,
    input wire logic                req_word,
    input wire logic                rsp_valid,
    input wire logic [15:0]         rsp_rdata,
    input wire logic                rsp_err,
    input wire logic                mem_sel,
    input wire logic                per_sel,
    input wire logic                per_word,
    input wire logic [15:0]         per_addr,
    input wire logic [7:0]          port_pin_i,
    input wire logic [7:0]          port_pin_o,
    input wire logic [7:0]          port_pin_oe
);
    import cbcu_pkg::*;
    // Taken plain accesses, classed by target area
    wire logic tk = req_valid && req_ready && req_job == JOB_ACC;
    wire logic rd8 = tk && !req_write && !req_word;
    wire logic ram = req_addr inside {[`CBCU_RAM_LO:`CBCU_RAM_HI]};
    wire logic io8 = req_addr inside {[16'hff80:16'hffcf]};
    wire logic io3 = req_addr inside {[`CBCU_IO3_LO:`CBCU_IO3_HI]};
    wire logic io16 = req_addr inside {[`CBCU_IO16_LO:`CBCU_IO16_HI]};
    wire logic emp = req_addr inside {[16'hf000:16'hfeff]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_mem_two_states:
    assert property (tk && ram |-> ##1 mem_sel[*2] ##1 (rsp_valid && !mem_sel))
        else $error("mem not 2 states");
    a_io_two_states:
    assert property (tk && io8 && !req_word |-> ##1 per_sel[*2]
        ##1 (rsp_valid && !per_sel)) else $error("io not 2 states");
    a_io_three_states:
    assert property (tk && io3 && !req_word |-> ##1 per_sel[*3]
        ##1 (rsp_valid && !per_sel)) else $error("slow io not 3 states");
    a_split_even_first:
    assert property (tk && io8 && req_word |->
        ##1 (per_sel && !per_addr[0] && !per_word)[*2]
        ##1 (per_sel && per_addr[0])[*2] ##1 rsp_valid)
        else $error("split wrong");
    a_wide_one_cycle:
    assert property (tk && io16 && req_word |-> ##1 (per_sel && per_word)[*2]
        ##1 (rsp_valid && !rsp_err)) else $error("wide wrong");
    a_wide_byte_refused:
    assert property (tk && io16 && !req_word |->
        (!per_sel throughout (##[1:3] rsp_valid)) ##0 rsp_err)
        else $error("wide byte not refused");
    a_empty_dropped:
    assert property (tk && emp |->
        ((!mem_sel && !per_sel) throughout (##[1:3] rsp_valid)) ##0 rsp_err)
        else $error("empty area strobed");
    a_dir_all_ones:
    assert property (rd8 && req_addr == `CBCU_PDIR_ADDR |->
        ##3 rsp_valid && rsp_rdata == 16'h00ff) else $error("dir read not ff");
    a_port_readback:
    assert property (rd8 && req_addr == `CBCU_PDATA_ADDR |-> ##3 rsp_valid
        && rsp_rdata == {8'h00, port_pin_oe & port_pin_o
        | ~port_pin_oe & port_pin_i}) else $error("port readback wrong");
endmodule
bind cbcu_bus_cycle_unit cbcu_bus_cycle_unit_asserts i_chk (.clk, .arst_n,
    .req_valid, .req_ready, .req_job, .req_addr, .req_write, .req_word,
    .rsp_valid, .rsp_rdata, .rsp_err, .mem_sel, .per_sel, .per_word,
    .per_addr, .port_pin_i, .port_pin_o, .port_pin_oe);
`default_nettype wire

// file: bench/cbcu_far_model.sv
// Memory and peripheral registers at the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module cbcu_far_model
(
    input wire logic         clk,
    input wire logic         mem_sel,
    input wire logic         mem_we,
    input wire logic [1:0]   mem_be,
    input wire logic [15:0]  mem_addr,
    input wire logic [15:0]  mem_wdata,
    output logic [15:0]      mem_rdata,
    input wire logic         per_sel,
    input wire logic         per_we,
    input wire logic         per_word,
    input wire logic [15:0]  per_addr,
    input wire logic [15:0]  per_wdata,
    output logic [15:0]      per_rdata
);
    logic [15:0] mem [0:255];
    logic [7:0]  prg [0:255];
    logic [15:0] last_m, last_p;
    wire logic [7:0] mi = mem_addr[8:1];
    wire logic [7:0] pa = per_addr[7:0];
    // Idle buses show the inverse of the last value
    assign mem_rdata = mem_sel ? mem[mi] : ~last_m;
    // Wide reads put the even byte on top
    assign per_rdata = !per_sel ? ~last_p : per_word
        ? {prg[pa & 8'hfe], prg[pa | 8'h01]} : {8'h00, prg[pa]};
    // Writes land at selected edges
    always @(posedge clk)
    begin
        last_m <= mem_rdata;
        last_p <= per_rdata;
        if (mem_sel && mem_we && mem_be[1])
            mem[mi][15:8] <= mem_wdata[15:8];
        if (mem_sel && mem_we && mem_be[0])
            mem[mi][7:0] <= mem_wdata[7:0];
        if (per_sel && per_we && per_word)
            prg[pa | 8'h01] <= per_wdata[7:0];
        if (per_sel && per_we)
            prg[per_word ? pa & 8'hfe : pa] <= per_word
                ? per_wdata[15:8] : per_wdata[7:0];
    end
endmodule
`default_nettype wire

// file: bench/cbcu_bus_cycle_unit_test.sv
// Self-checking bench of the internal bus cycle unit
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, a) \
    begin \
        comparisons++; \
        if ((a) !== (e)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH %s exp %h got %h", nm, e, a); \
        end \
    end
module cbcu_bus_cycle_unit_test;
    import cbcu_pkg::*;
    logic clk = 1'h0, arst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0;
    logic req_word = 1'h0, req_carry = 1'h0, exc_req = 1'h0, exc_done = 1'h0;
    logic halt_req = 1'h0, wake_req = 1'h0, subclk_sel = 1'h0;
    cbcu_job_e   req_job = JOB_ACC;
    cbcu_bitop_e req_bitop = OP_SET;
    cbcu_sub_e   halt_kind = SUB_STANDBY;
    logic [2:0]  req_bitnum = 3'h0;
    logic [7:0]  move_count_reg = 8'h00, port_pin_i = 8'h40;
    logic [15:0] req_addr = '0, req_wdata = '0;
    logic [15:0] move_source_reg = '0, move_dest_reg = '0;
    logic req_ready, rsp_valid, rsp_err, mem_sel, mem_we, per_sel, per_we;
    logic per_word;
    logic [1:0]  mem_be;
    logic [7:0]  port_pin_o, port_pin_oe;
    logic [15:0] rsp_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [15:0] per_addr, per_wdata, per_rdata;
    cbcu_cpu_e   cpu_state;
    cbcu_sub_e   cpu_submode;
    int n_mismatch = 0, comparisons = 0, cyc = 0;

    cbcu_bus_cycle_unit i_dut (.*);
    cbcu_far_model i_far (.*);

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hold request until taken, then await answer
    task automatic go(cbcu_job_e j, logic [15:0] a, logic w, logic wd,
                      logic [15:0] d);
        int k;
        @(negedge clk);
        req_job = j;
        {req_addr, req_write, req_word, req_wdata} = {a, w, wd, d};
        req_valid = 1'h1;
        for (k = 0; k < 50 && req_ready !== 1'h1; k++)
            @(negedge clk);
        @(negedge clk);
        req_valid = 1'h0;
        for (k = 0; k < 300 && rsp_valid !== 1'h1; k++)
            @(negedge clk);
        `CK("rsp_valid", 1'h1, rsp_valid)
    endtask
    task automatic wr(logic [15:0] a, logic wd, logic [15:0] d);
        go(JOB_ACC, a, 1'h1, wd, d);
    endtask
    task automatic rd(string nm, logic [15:0] a, logic wd, logic [15:0] e,
                      logic er);
        go(JOB_ACC, a, 1'h0, wd, 16'h0000);
        `CK(nm, e, rsp_rdata)
        `CK(nm, er, rsp_err)
    endtask
    task automatic bit_op(cbcu_bitop_e op, logic [2:0] n, logic [15:0] a);
        req_bitop = op;
        req_bitnum = n;
        req_carry = 1'h1;
        go(JOB_RMW, a, 1'h0, 1'h0, 16'h0000);
    endtask

    task automatic t_state;
        @(negedge clk);
        `CK("cpu_state", CPU_EXC, cpu_state)
        exc_done = 1'h1;
        @(negedge clk);
        exc_done = 1'h0;
        `CK("cpu_state", CPU_EXEC, cpu_state)
        halt_req = 1'h1;
        @(negedge clk);
        halt_req = 1'h0;
        `CK("cpu_state", CPU_HALT, cpu_state)
        `CK("cpu_submode", SUB_STANDBY, cpu_submode)
        wake_req = 1'h1;
        @(negedge clk);
        wake_req = 1'h0;
        `CK("cpu_state", CPU_EXEC, cpu_state)
        $display("state test done");
    endtask

    task automatic t_bus;
        wr(16'he800, 1'h1, 16'h1234);
        wr(16'he801, 1'h0, 16'h00cd);
        rd("ram word", 16'he800, 1'h1, 16'h12cd, 1'h0);
        rd("ram byte", 16'he800, 1'h0, 16'h0012, 1'h0);
        wr(16'hff80, 1'h1, 16'h5aa5);
        rd("split word", 16'hff80, 1'h1, 16'h5aa5, 1'h0);
        rd("odd byte", 16'hff81, 1'h0, 16'h00a5, 1'h0);
        wr(16'hff00, 1'h1, 16'hbeef);
        wr(16'hff00, 1'h0, 16'h0011);
        rd("wide word", 16'hff00, 1'h1, 16'hbeef, 1'h0);
        rd("wide byte", 16'hff01, 1'h0, 16'h00ff, 1'h1);
        wr(16'hff40, 1'h0, 16'h0077);
        rd("slow byte", 16'hff40, 1'h0, 16'h0077, 1'h0);
        wr(16'hf000, 1'h0, 16'h0055);
        rd("empty read", 16'hf000, 1'h0, 16'h00ff, 1'h1);
        $display("bus test done");
    endtask

    task automatic t_port;
        cbcu_bitop_e op[5] = '{OP_SET, OP_CLR, OP_NOT, OP_ST, OP_IST};
        logic [2:0]  bn[5] = '{3'h7, 3'h0, 3'h1, 3'h4, 3'h2};
        logic [7:0]  ex[5] = '{8'h8f, 8'h8e, 8'h8c, 8'h9c, 8'h98};
        wr(16'hffe8, 1'h0, 16'h003f);
        wr(16'hffd8, 1'h0, 16'h0080);
        rd("port read", 16'hffd8, 1'h0, 16'h0040, 1'h0);
        rd("dir read", 16'hffe8, 1'h0, 16'h00ff, 1'h0);
        bit_op(OP_SET, 3'h0, 16'hffd8);
        `CK("port_pin_o", 8'h41, port_pin_o)
        bit_op(OP_CLR, 3'h0, 16'hffe8);
        `CK("port_pin_oe", 8'hfe, port_pin_oe)
        // Shadow byte in RAM, edited bit by bit and written whole
        wr(16'he811, 1'h0, 16'h000f);
        foreach (op[i])
        begin
            bit_op(op[i], bn[i], 16'he811);
            rd("bit op", 16'he811, 1'h0, {8'h00, ex[i]}, 1'h0);
        end
        $display("port test done");
    endtask

    task automatic t_move;
        wr(16'he820, 1'h1, 16'ha1b2);
        wr(16'he822, 1'h1, 16'hc3d4);
        wr(16'he832, 1'h1, 16'h0000);
        // Destination end stays well below the top of the space
        {move_count_reg, move_source_reg, move_dest_reg} =
            {8'h03, 16'he820, 16'he830};
        go(JOB_MOVE, 16'h0000, 1'h0, 1'h0, 16'h0000);
        rd("move word", 16'he830, 1'h1, 16'ha1b2, 1'h0);
        rd("move tail", 16'he832, 1'h1, 16'hc300, 1'h0);
        move_count_reg = 8'h00;
        go(JOB_MOVE, 16'h0000, 1'h0, 1'h0, 16'h0000);
        rd("empty move", 16'he832, 1'h1, 16'hc300, 1'h0);
        $display("move test done");
    endtask

    initial
    begin
        repeat (5) @(negedge clk);
        arst_n = 1'h1;
        t_state;
        t_bus;
        t_port;
        t_move;
        wrap_up;
    end
endmodule
`default_nettype wire
